// ===== logic/pmw_pkg.sv
package pmw_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SYS_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h01;
  localparam logic [7:0] ADDR_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_MODE     = 8'h03;

  localparam int SM_CKS_LSB = 5;
  localparam int SM_FAST    = 4;
  localparam int SM_LRDY    = 3;
  localparam int SM_HRDY    = 2;
  localparam int SM_IDLE    = 1;
  localparam int SM_HL      = 0;
  localparam int CTRL_KEEP  = 7;
  localparam int ST_PDF     = 0;
  localparam int ST_WTO     = 1;

  localparam logic [2:0] CKS_RST    = 3'h0;
  localparam logic       FAST_RST   = 1'h0;
  localparam logic       IDLE_RST   = 1'h1;
  localparam logic       HL_RST     = 1'h1;
  localparam logic       KEEP_RST   = 1'h0;

  // ----------------------------------------------------------------
  // Oscillator edge counts and divider base
  // ----------------------------------------------------------------
  // Counting N edges of a free-running clock spans N-1..N periods
  localparam logic [7:0] XTAL_READY_CNT = 8'h80;
  localparam logic [7:0] FAST_INTERNAL_RC_READY_CNT = 8'h10;
  localparam logic [7:0] SHORT_WAKE_CNT = 8'h02;
  localparam logic [1:0] LRDY_CNT       = 2'h2;
  localparam logic [3:0] DIV_BASE       = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    MD_NORMAL     = 8'h01,
    MD_SLOW       = 8'h02,
    MD_DEEP_SLEEP = 8'h04,
    MD_SLEEP_SUB  = 8'h08,
    MD_IDLE_STOP  = 8'h10,
    MD_IDLE_RUN   = 8'h20,
    MD_WAKE       = 8'h40,
    MD_FAST_RUN   = 8'h80
  } pmw_mode_t;

  typedef enum logic [1:0] {
    SRC_OFF = 2'h0,
    SRC_HS  = 2'h1,
    SRC_SUB = 2'h2
  } pmw_src_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmw_bus_t;

  typedef struct packed {
    pmw_mode_t       mode;
    logic [7:0]      cnt;
    logic [1:0]      lrdy_cnt;
    logic [2:0][2:0] sync;
    logic [2:0]      cks;
    logic            fast_en;
    logic            idle_en;
    logic            hl_sel;
    logic            keep;
    logic            hrdy;
    logic            power_down_flag;
    logic            wto;
    logic            ret_slow;
    logic            fast;
    logic            on_sub;
    logic            short_w;
    logic [7:0]      rdata;
    pmw_src_t        src;
    logic            cpu_run;
    logic            hs_en;
    logic            sub_en;
    logic            tb_en;
    logic            wdt_clk_en;
    logic            wdt_clr;
    logic            io_hold;
    logic [2:0]      div_log2;
  } pmw_state_t;

endpackage

// ===== logic/pmw_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: Fast wake only from sleep with sub clock running or idle with clock stopped.
// R2: Waking from deep sleep ignores the fast wake enable.
// R3: Crystal with fast wake: wake on sub clock, switch after 128 crystal cycles.
// R4: Internal RC wakes in 15-16 cycles, slow RC in 1-2; fast bit ignored.
// R5: Deep sleep still costs 128 crystal cycles; idle with clock running 1-2.
// R6: Watchdog off means sub clock off, so no fast wake from deep sleep; the code keeps the sub clock on if the detector or idle is on.
// R7: Select bits pick normal or slow; halt picks idle or sleep by two bits.
// R8: Switching to sub clock stops high-speed oscillator and its divided clocks.
// R9: Software enters slow mode by clearing select and setting divider 000 or 001.
// R10: Slow mode needs low-speed ready; device reports it, software checks it.
// R11: Software returns to full speed, then checks high-speed ready flag.
// R12: Deep sleep only on halt with idle off, watchdog and detector off.
// R13: Deep sleep stops system, watchdog and time-base clocks; watchdog cleared.
// R14: Sub-clock sleep only on halt with idle off and watchdog or detector on.
// R15: Sub-clock sleep stops system and time-base clocks; watchdog cleared, counts.
// R16: Idle with clock stopped only on halt with idle on and keep off.
// R17: Idle stopped keeps sub clock and time base; watchdog cleared, resumes.
// R18: Sleep and idle keep memory, registers and port states.
// R19: Sleep and idle entry sets power-down flag, clears watchdog time-out flag.
// R20: Fast wake enable sits in bit 4, used only with crystal source.
// R21: Idle with clock running only on halt with idle on and keep on.
module pmw_ctrl (
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_nrst,
  // Register port
  input  wire pmw_pkg::pmw_bus_t i_bus,
  output logic [7:0]          o_rdata,
  // CPU core and configuration
  input  wire logic           i_halt,
  input  wire logic           i_wake,
  input  wire logic           i_wdt_timeout,
  input  wire logic           i_wdt_en,
  input  wire logic           i_lvd_en,
  input  wire logic           i_hs_is_rc,
  // Oscillator outputs
  input  wire logic           i_crystal_osc,
  input  wire logic           i_fast_internal_rc,
  input  wire logic           i_slow_internal_rc,
  // Clock and power controls
  output pmw_pkg::pmw_mode_t  o_mode,
  output pmw_pkg::pmw_src_t   o_sysclk_src,
  output logic [2:0]          o_hs_div_log2,
  output logic                o_cpu_run,
  output logic                o_hs_osc_en,
  output logic                o_sub_clk_en,
  output logic                o_tb_clk_en,
  output logic                o_wdt_clk_en,
  output logic                o_wdt_clear,
  output logic                o_io_hold
);

  pmw_pkg::pmw_state_t q;
  pmw_pkg::pmw_state_t d;


  // Synchronised oscillator edges
  logic       x_edge;
  logic       h_edge;
  logic       l_edge;
  logic       hs_edge;

  // Sequencer decode
  logic       slow_req;
  logic       sleeping;
  logic       tick;
  logic       done;

  // Count targets, raw oscillators and divider
  logic [7:0] hs_tgt;
  logic [7:0] tgt;
  logic [2:0] osc_in;
  logic [3:0] div_full;

  // ----------------------------------------------------------------
  // Oscillator sampling
  // ----------------------------------------------------------------
  // Stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
  assign osc_in = {i_slow_internal_rc, i_fast_internal_rc, i_crystal_osc};
  assign x_edge = q.sync[0][1] & ~q.sync[0][2];
  assign h_edge = q.sync[1][1] & ~q.sync[1][2];
  assign l_edge = q.sync[2][1] & ~q.sync[2][2];
  assign hs_edge = i_hs_is_rc ? h_edge : x_edge;
  assign hs_tgt = i_hs_is_rc ? pmw_pkg::FAST_INTERNAL_RC_READY_CNT : pmw_pkg::XTAL_READY_CNT; // [R4] [R5]

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign slow_req = ~q.hl_sel & (q.cks[2:1] == 2'h0); // [R7]
  assign sleeping = (q.mode == pmw_pkg::MD_DEEP_SLEEP) | (q.mode == pmw_pkg::MD_SLEEP_SUB)
                  | (q.mode == pmw_pkg::MD_IDLE_STOP) | (q.mode == pmw_pkg::MD_IDLE_RUN);

  // Wake counts run on the sub clock whenever the CPU will run from it
  assign tick = q.on_sub ? l_edge : hs_edge;
  assign tgt = (q.on_sub | q.short_w) ? pmw_pkg::SHORT_WAKE_CNT : hs_tgt; // [R4] [R5]
  assign done = tick & (q.cnt == tgt - 8'h01);

  // Divider codes 010 to 111 give log2 ratios 6 down to 1
  assign div_full = pmw_pkg::DIV_BASE - {1'b0, q.cks};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.wdt_clr = 1'b0;
    d.rdata = 8'h00;
    for (int i = 0; i < 3; i++) begin
      d.sync[i] = {q.sync[i][1:0], osc_in[i]};
    end

    // Register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        pmw_pkg::ADDR_SYS_MODE: begin
          d.cks = i_bus.wdata[pmw_pkg::SM_CKS_LSB +: 3];
          d.fast_en = i_bus.wdata[pmw_pkg::SM_FAST]; // [R20]
          d.idle_en = i_bus.wdata[pmw_pkg::SM_IDLE];
          d.hl_sel = i_bus.wdata[pmw_pkg::SM_HL];
        end
        pmw_pkg::ADDR_CTRL: begin
          d.keep = i_bus.wdata[pmw_pkg::CTRL_KEEP];
        end
        pmw_pkg::ADDR_STATUS: begin
          // Write one to clear; a hardware set later in this process wins
          if (i_bus.wdata[pmw_pkg::ST_PDF]) begin
            d.power_down_flag = 1'b0;
          end
          if (i_bus.wdata[pmw_pkg::ST_WTO]) begin
            d.wto = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered in the following cycle only
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        pmw_pkg::ADDR_SYS_MODE: begin
          d.rdata = {q.cks, q.fast_en, q.lrdy_cnt == pmw_pkg::LRDY_CNT, q.hrdy,
                     q.idle_en, q.hl_sel}; // [R10] [R11]
        end
        pmw_pkg::ADDR_CTRL: begin
          d.rdata = {q.keep, 7'h00};
        end
        pmw_pkg::ADDR_STATUS: begin
          d.rdata = {6'h00, q.wto, q.power_down_flag};
        end
        pmw_pkg::ADDR_MODE: begin
          d.rdata = q.mode;
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // Low-speed ready follows the sub clock, which only deep sleep stops
    if (q.mode == pmw_pkg::MD_DEEP_SLEEP) begin
      d.lrdy_cnt = 2'h0;
    end else if (l_edge && q.lrdy_cnt != pmw_pkg::LRDY_CNT) begin
      d.lrdy_cnt = q.lrdy_cnt + 2'h1; // [R10]
    end

    // Mode sequencer
    unique case (q.mode)
      pmw_pkg::MD_NORMAL, pmw_pkg::MD_SLOW: begin
        if (i_halt) begin
          // Only clocks change; memory, registers and ports stay as they are [R18]
          d.ret_slow = (q.mode == pmw_pkg::MD_SLOW);
          d.power_down_flag = 1'b1; // [R19]
          d.wto = 1'b0; // [R19]
          d.wdt_clr = 1'b1; // [R13] [R15] [R17]
          d.cnt = 8'h00;
          if (!q.idle_en && !i_wdt_en && !i_lvd_en) begin
            d.mode = pmw_pkg::MD_DEEP_SLEEP; // [R12]
          end else if (!q.idle_en) begin
            d.mode = pmw_pkg::MD_SLEEP_SUB; // [R14]
          end else if (!q.keep) begin
            d.mode = pmw_pkg::MD_IDLE_STOP; // [R16]
          end else begin
            d.mode = pmw_pkg::MD_IDLE_RUN; // [R21]
          end
          if (!q.idle_en || !q.keep) begin
            d.hrdy = 1'b0;
          end
        end else if (q.mode == pmw_pkg::MD_NORMAL) begin
          // The switch waits for a stable low-speed clock [R10]
          if (slow_req && q.lrdy_cnt == pmw_pkg::LRDY_CNT) begin
            d.mode = pmw_pkg::MD_SLOW; // [R7]
            d.hrdy = 1'b0; // [R8]
          end
        end else if (!slow_req) begin
          // CPU stays on the sub clock until the restarted oscillator is ready
          if (hs_edge) begin
            d.cnt = q.cnt + 8'h01;
          end
          if (hs_edge && q.cnt == hs_tgt - 8'h01) begin
            d.cnt = 8'h00;
            d.hrdy = 1'b1; // [R11]
            d.mode = pmw_pkg::MD_NORMAL; // [R7]
          end
        end else begin
          d.cnt = 8'h00;
        end
      end

      // Asleep: everything waits for the wake event
      pmw_pkg::MD_DEEP_SLEEP, pmw_pkg::MD_SLEEP_SUB,
      pmw_pkg::MD_IDLE_STOP, pmw_pkg::MD_IDLE_RUN: begin
        if (i_wake) begin
          d.mode = pmw_pkg::MD_WAKE;
          d.cnt = 8'h00;
          d.fast = 1'b0;
          d.on_sub = q.ret_slow; // [R4]
          d.short_w = (q.mode == pmw_pkg::MD_IDLE_RUN); // [R5]
          // Deep sleep has no sub clock, so the enable cannot apply [R2] [R6]
          if (!q.ret_slow && !i_hs_is_rc && q.fast_en
              && (q.mode == pmw_pkg::MD_SLEEP_SUB || q.mode == pmw_pkg::MD_IDLE_STOP)) begin
            d.fast = 1'b1; // [R1] [R20]
            d.on_sub = 1'b1; // [R3]
          end
        end
      end

      // Waiting for the chosen clock to settle
      pmw_pkg::MD_WAKE: begin
        if (tick) begin
          d.cnt = q.cnt + 8'h01;
        end
        if (done) begin
          d.cnt = 8'h00;
          d.on_sub = 1'b0;
          d.short_w = 1'b0;
          if (q.ret_slow) begin
            d.mode = pmw_pkg::MD_SLOW; // [R4]
          end else if (q.fast) begin
            d.mode = pmw_pkg::MD_FAST_RUN; // [R3]
          end else begin
            d.hrdy = 1'b1; // [R4] [R5]
            d.mode = pmw_pkg::MD_NORMAL;
          end
        end
      end

      // CPU runs from the sub clock while the crystal restarts
      pmw_pkg::MD_FAST_RUN: begin
        if (x_edge) begin
          d.cnt = q.cnt + 8'h01;
        end
        if (x_edge && q.cnt == pmw_pkg::XTAL_READY_CNT - 8'h01) begin
          d.cnt = 8'h00;
          d.fast = 1'b0;
          d.hrdy = 1'b1; // [R3]
          d.mode = pmw_pkg::MD_NORMAL; // [R3]
        end
      end

      // A corrupted code restarts the wake count rather than lock up
      default: begin
        d.mode = pmw_pkg::MD_WAKE;
        d.cnt = 8'h00;
      end
    endcase

    // A time-out in the entry cycle still lands
    if (i_wdt_timeout) begin
      d.wto = 1'b1;
    end

    // Registered outputs from the next state
    d.cpu_run = (d.mode == pmw_pkg::MD_NORMAL) | (d.mode == pmw_pkg::MD_SLOW)
              | (d.mode == pmw_pkg::MD_FAST_RUN);
    if (d.mode == pmw_pkg::MD_NORMAL
        || (d.mode == pmw_pkg::MD_IDLE_RUN && !d.ret_slow)) begin
      d.src = pmw_pkg::SRC_HS;
    end else if (d.mode == pmw_pkg::MD_SLOW || d.mode == pmw_pkg::MD_FAST_RUN
                 || (d.mode == pmw_pkg::MD_IDLE_RUN && d.ret_slow)) begin
      d.src = pmw_pkg::SRC_SUB; // [R3] [R17]
    end else begin
      d.src = pmw_pkg::SRC_OFF; // [R13] [R15] [R17]
    end

    // The divided timer clocks come from the same oscillator enable
    d.hs_en = (d.mode == pmw_pkg::MD_NORMAL) | (d.mode == pmw_pkg::MD_FAST_RUN)
            | ((d.mode == pmw_pkg::MD_WAKE) & ~d.ret_slow)
            | ((d.mode == pmw_pkg::MD_IDLE_RUN) & ~d.ret_slow)
            | ((d.mode == pmw_pkg::MD_SLOW) & ~slow_req); // [R8]

    // Only deep sleep stops the sub clock, which also feeds the watchdog
    d.sub_en = (d.mode != pmw_pkg::MD_DEEP_SLEEP); // [R13] [R17]
    d.wdt_clk_en = (d.mode != pmw_pkg::MD_DEEP_SLEEP) & i_wdt_en; // [R13] [R15]
    d.tb_en = (d.mode != pmw_pkg::MD_DEEP_SLEEP)
            & (d.mode != pmw_pkg::MD_SLEEP_SUB); // [R13] [R15] [R17]
    d.io_hold = ~d.cpu_run; // [R18]

    // Full speed selected means no division at all
    d.div_log2 = d.hl_sel ? 3'h0 : div_full[2:0];

    // Reset overrides all of the above; the oscillators stay enabled so the
    // first wake count after release has a clock to count
    if (!i_nrst) begin
      d = '0;
      d.mode = pmw_pkg::MD_WAKE;
      d.cks = pmw_pkg::CKS_RST;
      d.fast_en = pmw_pkg::FAST_RST;
      d.idle_en = pmw_pkg::IDLE_RST;
      d.hl_sel = pmw_pkg::HL_RST;
      d.keep = pmw_pkg::KEEP_RST;
      d.hs_en = 1'b1;
      d.sub_en = 1'b1;
      d.tb_en = 1'b1;
      d.io_hold = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign o_rdata = q.rdata;
  assign o_mode = q.mode;
  assign o_sysclk_src = q.src;
  assign o_hs_div_log2 = q.div_log2;
  assign o_cpu_run = q.cpu_run;
  assign o_hs_osc_en = q.hs_en;
  assign o_sub_clk_en = q.sub_en;
  assign o_tb_clk_en = q.tb_en;
  assign o_wdt_clk_en = q.wdt_clk_en;
  assign o_wdt_clear = q.wdt_clr;
  assign o_io_hold = q.io_hold;

endmodule
`default_nettype wire

// ===== dv/pmw_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pmw_chk (
  // Clock, reset and inputs
  input wire logic               i_clk,
  input wire logic               i_nrst,
  input wire pmw_pkg::pmw_bus_t  i_bus,
  input wire logic               i_halt,
  input wire logic               i_wake,
  input wire logic               i_wdt_en,
  input wire logic               i_lvd_en,
  // Outputs under watch
  input wire pmw_pkg::pmw_mode_t o_mode,
  input wire pmw_pkg::pmw_src_t  o_sysclk_src,
  input wire logic               o_cpu_run,
  input wire logic               o_hs_osc_en,
  input wire logic               o_sub_clk_en,
  input wire logic               o_tb_clk_en,
  input wire logic               o_wdt_clk_en,
  input wire logic               o_wdt_clear,
  input wire logic               o_io_hold
);
  // ----------------------------------------
  // Decoded modes and register shadows
  // ----------------------------------------
  logic m_norm, m_slow, m_deep, m_ssub, m_istop, m_irun, m_fast, go;
  logic idle_q, keep_q, deep_q;
  assign m_norm  = o_mode == pmw_pkg::MD_NORMAL;
  assign m_slow  = o_mode == pmw_pkg::MD_SLOW;
  assign m_deep  = o_mode == pmw_pkg::MD_DEEP_SLEEP;
  assign m_ssub  = o_mode == pmw_pkg::MD_SLEEP_SUB;
  assign m_istop = o_mode == pmw_pkg::MD_IDLE_STOP;
  assign m_irun  = o_mode == pmw_pkg::MD_IDLE_RUN;
  assign m_fast  = o_mode == pmw_pkg::MD_FAST_RUN;
  // Halt only counts in normal and slow mode, not in fast run
  assign go = i_halt && (m_norm || m_slow);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      idle_q <= pmw_pkg::IDLE_RST;
      keep_q <= pmw_pkg::KEEP_RST;
      deep_q <= 1'b0;
    end else begin
      if (i_bus.wr && i_bus.addr == pmw_pkg::ADDR_SYS_MODE) begin
        idle_q <= i_bus.wdata[pmw_pkg::SM_IDLE];
      end
      if (i_bus.wr && i_bus.addr == pmw_pkg::ADDR_CTRL) begin
        keep_q <= i_bus.wdata[pmw_pkg::CTRL_KEEP];
      end
      // Deep-sleep origin is remembered until the CPU runs on its own clock
      if (m_deep) begin
        deep_q <= 1'b1;
      end else if (m_norm || m_slow) begin
        deep_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  chk_halt_deep: assert property (go && !idle_q && !i_wdt_en && !i_lvd_en |=> m_deep)
    else $error("deep sleep not entered");
  chk_halt_sub: assert property (go && !idle_q && (i_wdt_en || i_lvd_en) |=> m_ssub)
    else $error("sub clock sleep not entered");
  chk_halt_istop: assert property (go && idle_q && !keep_q |=> m_istop)
    else $error("stopped idle not entered");
  chk_halt_irun: assert property (go && idle_q && keep_q |=> m_irun)
    else $error("running idle not entered");
  chk_entry_clear: assert property (go |=> o_wdt_clear && o_io_hold ##1 !o_wdt_clear)
    else $error("entry clear or hold wrong");
  chk_deep_clocks: assert property (m_deep && $past(m_deep) |->
    !o_sub_clk_en && !o_tb_clk_en && !o_wdt_clk_en && !o_cpu_run) else $error("deep clocks on");
  chk_sub_clocks: assert property (m_ssub |-> o_sub_clk_en && !o_tb_clk_en && !o_cpu_run)
    else $error("sub sleep clocks wrong");
  chk_idle_clocks: assert property (m_istop |-> o_sub_clk_en && o_tb_clk_en && !o_cpu_run)
    else $error("stopped idle clocks wrong");
  chk_slow_entry: assert property ($rose(m_slow) |->
    !o_hs_osc_en && o_sysclk_src == pmw_pkg::SRC_SUB) else $error("fast osc kept in slow");
  chk_fast_clock: assert property (m_fast |-> o_cpu_run && o_sysclk_src == pmw_pkg::SRC_SUB)
    else $error("fast wake not on sub clock");
  chk_deep_fast: assert property (deep_q |-> !m_fast)
    else $error("fast wake after deep sleep");
  chk_short_wake: assert property (m_irun && i_wake |=> !m_irun ##[1:20] m_norm)
    else $error("running idle wake too slow");
  chk_fast_len: assert property ($rose(m_fast) |-> m_fast [*8] ##[1:700] m_norm)
    else $error("fast wake handover wrong");
  cov_deep: cover property (m_deep);
  cov_fast: cover property ($rose(m_fast));
  cov_irun: cover property (m_irun);
  cov_slow: cover property ($rose(m_slow));
endmodule
bind pmw_ctrl pmw_chk i_pmw_chk (.i_clk, .i_nrst, .i_bus, .i_halt, .i_wake, .i_wdt_en,
  .i_lvd_en, .o_mode, .o_sysclk_src, .o_cpu_run, .o_hs_osc_en, .o_sub_clk_en, .o_tb_clk_en,
  .o_wdt_clk_en, .o_wdt_clear, .o_io_hold);
`default_nettype wire

// ===== dv/pmw_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmw_osc_model #(
  parameter int XH = 110,
  parameter int RH = 160,
  parameter int SH = 270
) (
  // Enables from the controller and the crystal or RC select
  input  wire logic i_hs_en,
  input  wire logic i_hs_is_rc,
  input  wire logic i_sub_en,
  // Oscillator outputs
  output var logic  o_crystal_osc,
  output var logic  o_fast_internal_rc,
  output var logic  o_slow_internal_rc
);
  // ----------------------------------------
  // Oscillators, stopped low when disabled
  // ----------------------------------------
  // A stopped source restarts from low, so its first edge costs a half period
  initial begin
    o_crystal_osc = 1'b0;
    o_fast_internal_rc = 1'b0;
    o_slow_internal_rc = 1'b0;
  end
  always #XH o_crystal_osc = (i_hs_en && !i_hs_is_rc) ? !o_crystal_osc : 1'b0;
  always #RH o_fast_internal_rc = (i_hs_en && i_hs_is_rc) ? !o_fast_internal_rc : 1'b0;
  always #SH o_slow_internal_rc = i_sub_en ? !o_slow_internal_rc : 1'b0;
endmodule
`default_nettype wire

// ===== dv/test_power_mode_wakeup_control.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) begin \
      bad_count++; \
      $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); \
    end \
  end
module test_power_mode_wakeup_control;
  logic i_clk, i_nrst, halt, wake, wto, wdt, low_voltage_detector, rc, xo, ro, so, run, hs_en, sub_en;
  pmw_pkg::pmw_bus_t  bus;
  pmw_pkg::pmw_mode_t mode;
  pmw_pkg::pmw_src_t  src;
  logic [7:0]         rdata;
  logic [2:0]         div;
  int                 bad_count;
  int                 num_checks;
  pmw_ctrl i_pmw_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
    .i_halt(halt), .i_wake(wake), .i_wdt_timeout(wto), .i_wdt_en(wdt), .i_lvd_en(low_voltage_detector),
    .i_hs_is_rc(rc), .i_crystal_osc(xo), .i_fast_internal_rc(ro), .i_slow_internal_rc(so),
    .o_mode(mode), .o_sysclk_src(src), .o_hs_div_log2(div), .o_cpu_run(run),
    .o_hs_osc_en(hs_en), .o_sub_clk_en(sub_en), .o_tb_clk_en(), .o_wdt_clk_en(),
    .o_wdt_clear(), .o_io_hold());
  pmw_osc_model i_pmw_osc_model (.i_hs_en(hs_en), .i_hs_is_rc(rc), .i_sub_en(sub_en),
    .o_crystal_osc(xo), .o_fast_internal_rc(ro), .o_slow_internal_rc(so));
  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Leaves the caller just after the edge where the mode moved on
  task automatic wait_leave(input pmw_pkg::pmw_mode_t m, output time t);
    t = $time;
    for (int n = 0; mode === m; n++) begin
      @(posedge i_clk);
      #1;
      if (n > 3000) begin
        `CHK(n, 0)
        complete_run();
      end
    end
    t = $time - t;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset;
    time dt;
    wait_leave(pmw_pkg::MD_WAKE, dt);
    `CHK(mode, pmw_pkg::MD_NORMAL)
    wr(pmw_pkg::ADDR_SYS_MODE, 8'h03);
    rd(pmw_pkg::ADDR_SYS_MODE, 8'h0F);
    rd(pmw_pkg::ADDR_CTRL, 8'h00);
    rd(8'h07, 8'h00);
  endtask
  task automatic sc_slow;
    time dt;
    for (int c = 0; c < 2; c++) begin
      wr(pmw_pkg::ADDR_SYS_MODE, {3'(c), 5'h02});
      // The write landed at the previous edge; the switch to slow happens at this edge
      @(posedge i_clk);
      #1;
      `CHK(mode, pmw_pkg::MD_SLOW)
      `CHK({hs_en, src}, {1'b0, pmw_pkg::SRC_SUB})
      rd(pmw_pkg::ADDR_SYS_MODE, {3'(c), 5'h0A});
      wr(pmw_pkg::ADDR_SYS_MODE, {3'(c + 2), 5'h02});
      #1;
      wait_leave(pmw_pkg::MD_SLOW, dt);
      `CHK({mode, src}, {pmw_pkg::MD_NORMAL, pmw_pkg::SRC_HS})
      rd(pmw_pkg::ADDR_SYS_MODE, {3'(c + 2), 5'h0E});
    end
    for (int c = 2; c < 9; c++) begin
      wr(pmw_pkg::ADDR_SYS_MODE, (c == 8) ? 8'h03 : {3'(c), 5'h02});
      rd(pmw_pkg::ADDR_MODE, 8'h01);
      `CHK(div, 3'(8 - c))
    end
  endtask
  task automatic sc_sleep(input logic r, i, k, w, l, f, input pmw_pkg::pmw_mode_t m);
    time dt;
    time p;
    time nn;
    logic fw;
    fw = f && !r && (m == pmw_pkg::MD_SLEEP_SUB || m == pmw_pkg::MD_IDLE_STOP);
    p = r ? 320 : 220;
    nn = (m == pmw_pkg::MD_IDLE_RUN) ? 2 : (r ? 16 : 128);
    wr(pmw_pkg::ADDR_CTRL, {k, 7'h00});
    wr(pmw_pkg::ADDR_SYS_MODE, {3'h0, f, 2'h0, i, 1'h1});
    wdt <= w;
    low_voltage_detector <= l;
    rc <= r;
    wto <= 1'b1;
    @(posedge i_clk);
    wto <= 1'b0;
    halt <= 1'b1;
    @(posedge i_clk);
    halt <= 1'b0;
    #1;
    `CHK({mode, run}, {m, 1'b0})
    rd(pmw_pkg::ADDR_STATUS, 8'h01);
    rd(pmw_pkg::ADDR_SYS_MODE, {3'h0, f, m != pmw_pkg::MD_DEEP_SLEEP,
      m == pmw_pkg::MD_IDLE_RUN, i, 1'b1});
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    #1;
    wait_leave(pmw_pkg::MD_WAKE, dt);
    if (fw) begin
      `CHK(mode, pmw_pkg::MD_FAST_RUN)
      `CHK(dt <= 1500, 1'b1)
      wait_leave(pmw_pkg::MD_FAST_RUN, dt);
    end
    `CHK(mode, pmw_pkg::MD_NORMAL)
    `CHK(dt >= (nn - 1) * p - 100 && dt <= nn * p + 400, 1'b1)
    wr(pmw_pkg::ADDR_STATUS, 8'h03);
    rd(pmw_pkg::ADDR_STATUS, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    {i_nrst, halt, wake, wto, wdt, low_voltage_detector, rc} = '0;
    bus = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    sc_reset();
    sc_slow();
    sc_sleep(0, 0, 0, 0, 0, 1, pmw_pkg::MD_DEEP_SLEEP);
    sc_sleep(0, 0, 0, 1, 0, 1, pmw_pkg::MD_SLEEP_SUB);
    sc_sleep(0, 0, 0, 0, 1, 0, pmw_pkg::MD_SLEEP_SUB);
    sc_sleep(0, 1, 0, 0, 0, 1, pmw_pkg::MD_IDLE_STOP);
    sc_sleep(0, 1, 1, 0, 0, 1, pmw_pkg::MD_IDLE_RUN);
    sc_sleep(1, 0, 0, 1, 0, 1, pmw_pkg::MD_SLEEP_SUB);
    complete_run();
  end
endmodule
`default_nettype wire
